// File: servo_cmd_map.svh
// Command codes, keys, ranges and timing constants for the servo command handler
`ifndef SERVO_CMD_MAP_SVH
`define SERVO_CMD_MAP_SVH
`define CMD_STATUS_READ 8'h01
`define CMD_PARAM_READ 8'h05
`define CMD_PIN_READ 8'h12
`define CMD_STATUS_CLEAR 8'h81
`define CMD_PARAM_WRITE 8'h84
`define CMD_OP_MODE 8'h8b
`define CMD_IO_DISABLE 8'h90
`define CMD_TEST_INPUT 8'h92
`define CMD_TEST_DATA 8'ha0
`define DN_00 8'h00
`define DN_01 8'h01
`define DN_03 8'h03
`define DN_10 8'h10
`define DN_11 8'h11
`define DN_12 8'h12
`define DN_13 8'h13
`define DN_15 8'h15
`define DN_40 8'h40
`define DN_A0 8'ha0
`define DN_PARAM_MAX 8'h54
`define PROTECT_KEY 16'h1ea5
`define MODE_MAX 16'h0004
`define SPEED_MAX 16'h7fff
`define ACCEL_MAX 32'h7fffffff
`define DP_MAX 4'h5
`define WMODE_EEP 4'h0
`define WMODE_RAM 4'h3
`define INHIBIT_PARAM 7'h13
`define PARAM_COUNT 85
`define EXEMPT_MASK 32'h0000_0006
`define IDLE_TIMEOUT_NS 500000000
`define CLK_PERIOD_NS 4
`endif

// File: servo_cmd_pkg.sv
// Types shared by the servo command handler
`default_nettype none
package servo_cmd_pkg;
    typedef enum logic [2:0] {
        MODE_NORMAL, MODE_JOG, MODE_POSITION, MODE_MOTORLESS, MODE_FORCED_OUT
    } op_mode_type;
    typedef enum logic [1:0] {
        REPLY_NONE, REPLY_ACK, REPLY_DATA, REPLY_ERROR
    } reply_type;
endpackage : servo_cmd_pkg
`default_nettype wire

// File: servo_link_watchdog.sv
// Traffic watchdog for test operation
`timescale 1ns/1ps
`default_nettype none
`include "servo_cmd_map.svh"
module servo_link_watchdog #(
    parameter int unsigned TIMEOUT_CYCLES = `IDLE_TIMEOUT_NS / `CLK_PERIOD_NS
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_armed,
    input wire logic i_kick,
    output logic o_expired
);
    // Idle counter, restarts on any frame
    logic [27:0] idle_q;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            idle_q <= 28'h0;
            o_expired <= 1'b0;
        end else if (!i_armed || i_kick) begin
            idle_q <= 28'h0;
            o_expired <= 1'b0;
        end else if (idle_q >= TIMEOUT_CYCLES[27:0]) begin
            o_expired <= 1'b1;
        end else begin
            idle_q <= idle_q + 28'h1;
        end
    end
endmodule : servo_link_watchdog
`default_nettype wire

// File: servo_param_store.sv
// Parameter memory with a working copy and a nonvolatile commit pulse
`timescale 1ns/1ps
`default_nettype none
`include "servo_cmd_map.svh"
module servo_param_store (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_wr,
    input wire logic i_wr_nv,
    input wire logic [6:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wdp,
    output logic [31:0] o_rdata,
    output logic [3:0] o_rdp,
    output logic o_nv_write,
    output logic [31:0] o_inhibit
);
    // Working copy and its decimal point positions
    logic [31:0] ram_q [`PARAM_COUNT];
    logic [3:0] dp_q [`PARAM_COUNT];
    // Working copy updated on any accepted write
    always_ff @(posedge i_core_clk) begin
        if (i_wr) begin
            ram_q[i_addr] <= i_wdata;
            dp_q[i_addr] <= i_wdp;
        end
        o_rdata <= ram_q[i_addr];
        o_rdp <= dp_q[i_addr];
    end
    // Nonvolatile commit pulse and inhibit shadow
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_nv_write <= 1'b0;
            o_inhibit <= 32'h0;
        end else begin
            o_nv_write <= i_wr && i_wr_nv;
            if (i_wr && i_addr == `INHIBIT_PARAM) begin
                o_inhibit <= i_wdata;
            end
        end
    end
endmodule : servo_param_store
`default_nettype wire

// File: servo_serial_command_handler.sv
// Slave-side interpreter for servo serial read and write commands
`timescale 1ns/1ps
`default_nettype none
`include "servo_cmd_map.svh"
// What this block does
// - Mode command selects exit, jog, position, motorless, forced
// - Disable key forces inputs off except exempt
// - Output disable drives outputs from forced pattern
// - Input enable restores real input recognition
// - Output enable returns outputs to normal
// - Command 92 sets test inputs, forced outputs
// - Test speed accepted in 0000 to 7FFF
// - Accel time constant accepted up to 7FFFFFFF
// - Keyed clear zeroes accel time constant
// - Signed moving distance stored in pulses
// - Keyed temporary stop halts test run
// - Decimal writes need a point position
// - Status read returns value with processing info
// - Keyed status clear zeroes feedback pulse total
// - Parameter read for numbers 00 to 54
// - Read reply flags inhibit-disabled parameters
// - Parameter write point position 0 to 5
// - Write mode 0 nonvolatile, 3 RAM only
// - Pin read returns external input states
// - Half second silence stops test motion
module servo_serial_command_handler (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd,
    input wire logic [7:0] i_data_no,
    input wire logic [31:0] i_data,
    input wire logic [3:0] i_dp,
    input wire logic [3:0] i_write_mode,
    input wire logic i_dp_given,
    input wire logic [31:0] i_status_value,
    input wire logic [31:0] i_discrete_inputs,
    input wire logic [15:0] i_analog_input,
    input wire logic i_pulse_train,
    input wire logic [31:0] i_normal_outputs,
    output logic o_reply_valid,
    output servo_cmd_pkg::reply_type o_reply_kind,
    output logic [31:0] o_reply_data,
    output logic [3:0] o_reply_dp,
    output logic o_reply_read_ok,
    output servo_cmd_pkg::op_mode_type o_op_mode,
    output logic [31:0] o_discrete_inputs,
    output logic [15:0] o_analog_input,
    output logic o_pulse_train,
    output logic [31:0] o_discrete_outputs,
    output logic [15:0] o_test_speed,
    output logic [31:0] o_test_accel,
    output logic [31:0] o_test_distance,
    output logic o_test_stop,
    output logic o_feedback_clear,
    output logic o_link_stop,
    output logic o_nv_write
);
    // Synchronisers for pin-level inputs
    logic [31:0] di_meta_q, di_sync_q;
    logic [15:0] ai_meta_q, ai_sync_q;
    logic pt_meta_q, pt_sync_q;
    // Control state
    logic inputs_off_q; // Real inputs ignored
    logic outputs_forced_q; // Outputs taken from pattern
    logic [31:0] test_in_q; // Test input pattern
    logic [31:0] force_out_q; // Forced output pattern
    logic param_rd_q; // Parameter read pending one cycle
    logic [6:0] param_addr_q; // Parameter under access
    logic stop_expired; // Watchdog expired
    logic [31:0] rd_data;
    logic [3:0] rd_dp;
    logic [31:0] inhibit_val;
    logic pw_ok; // Parameter write accepted
    logic frame_key_ok; // Valid frame carrying the protection key
    logic [15:0] frame_sel; // Command and data number of the frame

    // Key check used by every protected command
    function automatic logic key_ok(input logic [31:0] d);
        key_ok = d[15:0] == `PROTECT_KEY;
    endfunction : key_ok

    // Command and data number match
    function automatic logic hit(input logic [7:0] c, input logic [7:0] n);
        hit = i_cmd_valid && i_cmd == c && i_data_no == n;
    endfunction : hit

    // Parameter number is in the map
    function automatic logic param_no_ok(input logic [7:0] n);
        param_no_ok = n <= `DN_PARAM_MAX;
    endfunction : param_no_ok

    assign pw_ok = i_cmd_valid && i_cmd == `CMD_PARAM_WRITE && param_no_ok(i_data_no)
        && i_dp <= `DP_MAX && (i_dp_given || i_dp == 4'h0)
        && (i_write_mode == `WMODE_EEP || i_write_mode == `WMODE_RAM);
    // Plain frame signals, so that assertions see sampled values, not function globals
    assign frame_key_ok = i_cmd_valid && key_ok(i_data);
    assign frame_sel = {i_cmd, i_data_no};

    // Two-flop pin synchronisers
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            di_meta_q <= 32'h0;
            di_sync_q <= 32'h0;
            ai_meta_q <= 16'h0;
            ai_sync_q <= 16'h0;
            pt_meta_q <= 1'b0;
            pt_sync_q <= 1'b0;
        end else begin
            di_meta_q <= i_discrete_inputs;
            di_sync_q <= di_meta_q;
            ai_meta_q <= i_analog_input;
            ai_sync_q <= ai_meta_q;
            pt_meta_q <= i_pulse_train;
            pt_sync_q <= pt_meta_q;
        end
    end

    // Input and output disable state
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            inputs_off_q <= 1'b0;
            outputs_forced_q <= 1'b0;
        end else begin
            if (hit(`CMD_IO_DISABLE, `DN_00) && key_ok(i_data)) begin
                inputs_off_q <= 1'b1;
            end else if (hit(`CMD_IO_DISABLE, `DN_10) && key_ok(i_data)) begin
                inputs_off_q <= 1'b0;
            end
            if (hit(`CMD_IO_DISABLE, `DN_03) && key_ok(i_data)) begin
                outputs_forced_q <= 1'b1;
            end else if (hit(`CMD_IO_DISABLE, `DN_13) && key_ok(i_data)) begin
                outputs_forced_q <= 1'b0;
            end
        end
    end

    // Operation mode selection
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_op_mode <= servo_cmd_pkg::MODE_NORMAL;
        end else if (hit(`CMD_OP_MODE, `DN_00) && i_data[15:0] <= `MODE_MAX
                && i_data[31:16] == 16'h0) begin
            o_op_mode <= servo_cmd_pkg::op_mode_type'(i_data[2:0]);
        end
    end

    // Test patterns from command 92 and A0-01
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            test_in_q <= 32'h0;
            force_out_q <= 32'h0;
        end else begin
            if (hit(`CMD_TEST_INPUT, `DN_00)) begin
                test_in_q <= i_data;
            end
            if (hit(`CMD_TEST_INPUT, `DN_A0) || hit(`CMD_TEST_DATA, `DN_01)) begin
                force_out_q <= i_data;
            end
        end
    end

    // Test-operation speed, accel and distance
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_test_speed <= 16'h0;
            o_test_accel <= 32'h0;
            o_test_distance <= 32'h0;
        end else begin
            if (hit(`CMD_TEST_DATA, `DN_10) && i_data[31:16] == 16'h0
                    && i_data[15:0] <= `SPEED_MAX) begin
                o_test_speed <= i_data[15:0];
            end
            if (hit(`CMD_TEST_DATA, `DN_11) && i_data <= `ACCEL_MAX) begin
                o_test_accel <= i_data;
            end else if (hit(`CMD_TEST_DATA, `DN_12) && key_ok(i_data)) begin
                o_test_accel <= 32'h0;
            end
            if (hit(`CMD_TEST_DATA, `DN_13)) begin
                o_test_distance <= i_data;
            end
        end
    end

    // Temporary stop, held until the next mode command with data number 00, accepted or not
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_test_stop <= 1'b0;
        end else if (hit(`CMD_TEST_DATA, `DN_15) && key_ok(i_data)) begin
            o_test_stop <= 1'b1;
        end else if (hit(`CMD_OP_MODE, `DN_00)) begin
            o_test_stop <= 1'b0;
        end
    end

    // Signal outputs seen by the rest of the amplifier
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_discrete_inputs <= 32'h0;
            o_analog_input <= 16'h0;
            o_pulse_train <= 1'b0;
            o_discrete_outputs <= 32'h0;
        end else begin
            if (inputs_off_q) begin
                // Exempt bits keep their real level
                o_discrete_inputs <= (test_in_q & ~`EXEMPT_MASK)
                    | (di_sync_q & `EXEMPT_MASK);
                o_analog_input <= 16'h0;
                o_pulse_train <= 1'b0;
            end else begin
                o_discrete_inputs <= di_sync_q;
                o_analog_input <= ai_sync_q;
                o_pulse_train <= pt_sync_q;
            end
            o_discrete_outputs <= outputs_forced_q ? force_out_q
                : i_normal_outputs;
        end
    end

    // Feedback pulse total clear pulse
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_feedback_clear <= 1'b0;
        end else begin
            o_feedback_clear <= hit(`CMD_STATUS_CLEAR, `DN_00) && key_ok(i_data);
        end
    end

    // Parameter read pipeline
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            param_rd_q <= 1'b0;
        end else begin
            param_rd_q <= i_cmd_valid && i_cmd == `CMD_PARAM_READ && param_no_ok(i_data_no);
        end
    end
    assign param_addr_q = i_data_no[6:0];

    // Reply generation
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reply_valid <= 1'b0;
            o_reply_kind <= servo_cmd_pkg::REPLY_NONE;
            o_reply_data <= 32'h0;
            o_reply_dp <= 4'h0;
            o_reply_read_ok <= 1'b0;
        end else begin
            o_reply_valid <= 1'b0;
            o_reply_read_ok <= 1'b0;
            if (param_rd_q) begin
                o_reply_valid <= 1'b1;
                o_reply_kind <= servo_cmd_pkg::REPLY_DATA;
                o_reply_data <= rd_data;
                o_reply_dp <= rd_dp;
                o_reply_read_ok <= inhibit_val[3:0] == 4'h0;
            end else if (i_cmd_valid && i_cmd == `CMD_STATUS_READ) begin
                o_reply_valid <= 1'b1;
                o_reply_kind <= servo_cmd_pkg::REPLY_DATA;
                o_reply_data <= i_status_value;
                o_reply_dp <= 4'h0;
                o_reply_read_ok <= 1'b1;
            end else if (hit(`CMD_PIN_READ, `DN_40)) begin
                o_reply_valid <= 1'b1;
                o_reply_kind <= servo_cmd_pkg::REPLY_DATA;
                o_reply_data <= di_sync_q;
                o_reply_dp <= 4'h0;
                o_reply_read_ok <= 1'b1;
            end else if (i_cmd_valid && i_cmd != `CMD_PARAM_READ) begin
                o_reply_valid <= 1'b1;
                o_reply_kind <= cmd_good() ? servo_cmd_pkg::REPLY_ACK
                    : servo_cmd_pkg::REPLY_ERROR;
            end else if (i_cmd_valid && !param_no_ok(i_data_no)) begin
                o_reply_valid <= 1'b1;
                o_reply_kind <= servo_cmd_pkg::REPLY_ERROR;
            end
        end
    end

    // Whether a write-type command was accepted
    function automatic logic cmd_good();
        logic k;
        k = key_ok(i_data);
        unique case (i_cmd)
            `CMD_STATUS_CLEAR: cmd_good = i_data_no == `DN_00 && k;
            `CMD_PARAM_WRITE: cmd_good = pw_ok;
            `CMD_OP_MODE: cmd_good = i_data_no == `DN_00 && i_data <= 32'(`MODE_MAX);
            `CMD_IO_DISABLE: cmd_good = k && (i_data_no == `DN_00 || i_data_no == `DN_03
                || i_data_no == `DN_10 || i_data_no == `DN_13);
            `CMD_TEST_INPUT: cmd_good = i_data_no == `DN_00 || i_data_no == `DN_A0;
            `CMD_TEST_DATA: cmd_good = i_data_no == `DN_01 || i_data_no == `DN_13
                || (i_data_no == `DN_10 && i_data <= 32'(`SPEED_MAX))
                || (i_data_no == `DN_11 && i_data <= `ACCEL_MAX)
                || ((i_data_no == `DN_12 || i_data_no == `DN_15) && k);
            default: cmd_good = 1'b0;
        endcase
    endfunction : cmd_good

    servo_param_store u_params (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_wr(pw_ok),
        .i_wr_nv(i_write_mode == `WMODE_EEP),
        .i_addr(param_addr_q),
        .i_wdata(i_data),
        .i_wdp(i_dp),
        .o_rdata(rd_data),
        .o_rdp(rd_dp),
        .o_nv_write(o_nv_write),
        .o_inhibit(inhibit_val)
    );

    servo_link_watchdog u_watchdog (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_armed(o_op_mode != servo_cmd_pkg::MODE_NORMAL),
        .i_kick(i_cmd_valid),
        .o_expired(stop_expired)
    );

    // Registered copy of the watchdog stop
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_link_stop <= 1'b0;
        end else begin
            o_link_stop <= stop_expired;
        end
    end

    a_input_disable: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        frame_key_ok && frame_sel == {`CMD_IO_DISABLE, `DN_00} |-> ##2 o_analog_input == 16'h0)
        else $error("inputs not disabled");
    a_output_force: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        outputs_forced_q |=> o_discrete_outputs == $past(force_out_q))
        else $error("outputs not forced");
    a_input_enable: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        frame_key_ok && frame_sel == {`CMD_IO_DISABLE, `DN_10} |=> !inputs_off_q)
        else $error("inputs not restored");
    a_output_release: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        frame_key_ok && frame_sel == {`CMD_IO_DISABLE, `DN_13} |=> ##1 o_discrete_outputs
        == $past(i_normal_outputs)) else $error("outputs not released");
    a_accel_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        frame_key_ok && frame_sel == {`CMD_TEST_DATA, `DN_12} |=> o_test_accel == 32'h0)
        else $error("accel not cleared");
    a_temp_stop: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        frame_key_ok && frame_sel == {`CMD_TEST_DATA, `DN_15} |=> o_test_stop)
        else $error("stop not raised");
    a_status_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_feedback_clear |-> $past(frame_key_ok)
        && $past(frame_sel) == {`CMD_STATUS_CLEAR, `DN_00})
        else $error("spurious clear");
    a_bad_key: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        i_cmd_valid && i_cmd == `CMD_IO_DISABLE && !key_ok(i_data) |=>
        $stable(inputs_off_q) && o_reply_kind == servo_cmd_pkg::REPLY_ERROR)
        else $error("bad key accepted");
    c_mode_jog: cover property (@(posedge i_core_clk) o_op_mode == servo_cmd_pkg::MODE_JOG);
    c_param_read: cover property (@(posedge i_core_clk) param_rd_q);
    c_link_stop: cover property (@(posedge i_core_clk) o_link_stop);
endmodule : servo_serial_command_handler
`default_nettype wire

// File: servo_master_model.sv
// Master station model that sends decoded command frames and waits for answers
`timescale 1ns/1ps
`default_nettype none
module servo_master_model (
    input wire logic i_core_clk,
    input wire logic i_reply_valid,
    output logic o_cmd_valid,
    output logic [7:0] o_cmd,
    output logic [7:0] o_data_no,
    output logic [31:0] o_data,
    output logic [3:0] o_dp,
    output logic [3:0] o_write_mode,
    output logic o_dp_given
);
    // Idle link at time zero
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd = 8'h00;
        o_data_no = 8'h00;
        o_data = 32'h0;
        o_dp = 4'h0;
        o_write_mode = 4'h0;
        o_dp_given = 1'b0;
    end
    // One frame for a single cycle, then at most six cycles for its answer
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] no, input logic [31:0] data,
        input logic [3:0] dp, input logic dpg, input logic [3:0] wm, output logic got);
        got = 1'b0;
        @(posedge i_core_clk);
        o_cmd_valid <= 1'b1;
        o_cmd <= cmd;
        o_data_no <= no;
        o_data <= data;
        o_dp <= dp;
        o_dp_given <= dpg;
        o_write_mode <= wm;
        @(posedge i_core_clk);
        o_cmd_valid <= 1'b0;
        // Stale data and data number are scrambled so nothing may lean on them after the frame
        o_data <= ~data;
        o_data_no <= ~no;
        for (int n = 0; n < 6 && got !== 1'b1; n++) begin
            @(negedge i_core_clk);
            got = (i_reply_valid === 1'b1);
        end
    endtask : xfer
endmodule : servo_master_model
`default_nettype wire

// File: servo_serial_command_handler_tb_top.sv
// Self-checking bench for the servo serial command handler
`timescale 1ns/1ps
`default_nettype none
module servo_serial_command_handler_tb_top;
    localparam servo_cmd_pkg::reply_type ACK = servo_cmd_pkg::REPLY_ACK;
    localparam servo_cmd_pkg::reply_type DAT = servo_cmd_pkg::REPLY_DATA;
    localparam servo_cmd_pkg::reply_type ERR = servo_cmd_pkg::REPLY_ERROR;
    localparam logic [31:0] KEY = 32'h0000_1ea5; // Protection key
    logic i_core_clk, i_rst_n, i_cmd_valid, i_dp_given, i_pulse_train;
    logic [7:0] i_cmd, i_data_no, pn;
    logic [31:0] i_data, i_status_value, i_discrete_inputs, i_normal_outputs, v, p;
    logic [3:0] i_dp, i_write_mode, o_reply_dp;
    logic [15:0] i_analog_input, o_analog_input, o_test_speed;
    logic o_reply_valid, o_reply_read_ok, o_pulse_train, o_test_stop, o_feedback_clear;
    logic o_link_stop, o_nv_write, got;
    logic [31:0] o_reply_data, o_discrete_inputs, o_discrete_outputs;
    logic [31:0] o_test_accel, o_test_distance;
    servo_cmd_pkg::reply_type o_reply_kind;
    servo_cmd_pkg::op_mode_type o_op_mode;
    int n_mismatch = 0;
    int n_compared = 0;
    int n_clr = 0; // Feedback clear pulses seen
    int n_nv = 0; // Nonvolatile write pulses seen
    int seed;
    int i;
    servo_serial_command_handler servo_serial_command_handler_i (.i_core_clk, .i_rst_n,
        .i_cmd_valid, .i_cmd, .i_data_no, .i_data, .i_dp, .i_write_mode, .i_dp_given,
        .i_status_value, .i_discrete_inputs, .i_analog_input, .i_pulse_train,
        .i_normal_outputs, .o_reply_valid, .o_reply_kind, .o_reply_data, .o_reply_dp,
        .o_reply_read_ok, .o_op_mode, .o_discrete_inputs, .o_analog_input, .o_pulse_train,
        .o_discrete_outputs, .o_test_speed, .o_test_accel, .o_test_distance, .o_test_stop,
        .o_feedback_clear, .o_link_stop, .o_nv_write);
    servo_master_model servo_master_model_i (.i_core_clk, .i_reply_valid(o_reply_valid),
        .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd), .o_data_no(i_data_no), .o_data(i_data),
        .o_dp(i_dp), .o_write_mode(i_write_mode), .o_dp_given(i_dp_given));
    // Core clock, 4 ns period
    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end
    // Counts one-cycle pulses so later checks see them
    always @(negedge i_core_clk) begin
        if (o_feedback_clear === 1'b1) n_clr++;
        if (o_nv_write === 1'b1) n_nv++;
    end
    // Prints the verdict and ends the run
    task automatic summarize;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    // Compares one value
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch at %0t: value %h, expected %h", $time, g, e);
        end
    endtask : chk
    // Sends one frame and compares the reply kind; a missing reply ends the run
    task automatic run(input logic [7:0] c, input logic [7:0] no, input logic [31:0] d,
        input servo_cmd_pkg::reply_type k, input logic [3:0] dp = 4'h0,
        input logic dpg = 1'b1, input logic [3:0] wm = 4'h3);
        servo_master_model_i.xfer(c, no, d, dp, dpg, wm, got);
        n_compared++;
        if (got !== 1'b1 || o_reply_kind !== k) begin
            n_mismatch++;
            $display("mismatch at %0t: reply %0d to command %h/%h", $time, o_reply_kind, c, no);
            if (got !== 1'b1) summarize();
        end
    endtask : run
    // Lets filtered paths settle
    task automatic settle;
        repeat (4) @(negedge i_core_clk);
    endtask : settle
    // Inputs seen while disabled: test pattern, stroke limits from the pins
    function automatic logic [31:0] exp_in(input logic [31:0] pat, input logic [31:0] pins);
        return (pat & ~32'h6) | (pins & 32'h6);
    endfunction : exp_in
    // Main sequence
    initial begin
        seed = 64658;
        i_rst_n = 1'b0;
        i_discrete_inputs = $random(seed);
        i_analog_input = 16'h1 | 16'($random(seed));
        i_pulse_train = 1'b1;
        i_normal_outputs = $random(seed);
        i_status_value = $random(seed);
        repeat (16) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        chk({o_op_mode, o_test_speed}, 0);
        // Every mode, then refused values
        for (i = 0; i < 5; i++) begin
            run(8'h8b, 8'h00, i, ACK);
            chk(o_op_mode, i);
        end
        run(8'h8b, 8'h00, 32'h5, ERR);
        run(8'h8b, 8'h00, 32'h1_0001, ERR);
        chk(o_op_mode, 4);
        run(8'ha0, 8'h15, KEY ^ 32'h1, ERR);
        chk(o_test_stop, 0);
        run(8'ha0, 8'h15, KEY, ACK);
        chk(o_test_stop, 1);
        // Speed, time constant and distance with their boundaries
        v = $random(seed) & 32'h7fff;
        run(8'ha0, 8'h10, 32'h7fff, ACK);
        chk(o_test_speed, 32'h7fff);
        run(8'ha0, 8'h10, v, ACK);
        run(8'ha0, 8'h10, 32'h8000, ERR);
        chk(o_test_speed, v);
        v = $random(seed) & 32'h7fffffff;
        run(8'ha0, 8'h11, v, ACK);
        run(8'ha0, 8'h11, 32'h8000_0000, ERR);
        run(8'ha0, 8'h12, KEY ^ 32'h10, ERR);
        chk(o_test_accel, v);
        run(8'ha0, 8'h12, KEY, ACK);
        chk(o_test_accel, 0);
        run(8'ha0, 8'h13, 32'h8000_0000, ACK);
        chk(o_test_distance, 32'h8000_0000);
        v = $random(seed);
        run(8'ha0, 8'h13, v, ACK);
        chk(o_test_distance, v);
        chk(o_link_stop, 0);
        run(8'h8b, 8'h00, 32'h0, ACK);
        chk({o_op_mode, o_test_stop}, 0);
        // Input disable and enable
        p = $random(seed);
        @(posedge i_core_clk);
        i_discrete_inputs <= $random(seed);
        run(8'h92, 8'h00, p, ACK);
        run(8'h90, 8'h00, KEY ^ 32'h100, ERR);
        run(8'h90, 8'h05, KEY, ERR);
        settle();
        chk(o_discrete_inputs, i_discrete_inputs);
        run(8'h90, 8'h00, KEY, ACK);
        settle();
        chk(o_discrete_inputs, exp_in(p, i_discrete_inputs));
        chk({o_analog_input, o_pulse_train}, 0);
        run(8'h90, 8'h10, KEY, ACK);
        settle();
        chk({o_analog_input, o_pulse_train}, {i_analog_input, i_pulse_train});
        chk(o_discrete_inputs, i_discrete_inputs);
        // Forced outputs and their release
        p = $random(seed);
        run(8'h92, 8'ha0, p, ACK);
        run(8'h90, 8'h03, KEY, ACK);
        settle();
        chk(o_discrete_outputs, p);
        p = $random(seed);
        run(8'ha0, 8'h01, p, ACK);
        settle();
        chk(o_discrete_outputs, p);
        run(8'h90, 8'h13, KEY, ACK);
        settle();
        chk(o_discrete_outputs, i_normal_outputs);
        // Status read and clear
        run(8'h01, 8'h80, 32'h0, DAT);
        chk(o_reply_data, i_status_value);
        run(8'h81, 8'h00, KEY, ACK);
        run(8'h81, 8'h00, KEY ^ 32'h1000, ERR);
        settle();
        chk(n_clr, 1);
        // Parameter writes with every point position, each read back
        run(8'h84, 8'h13, 32'h0, ACK);
        for (i = 0; i < 6; i++) begin
            pn = (i == 0) ? 8'h00 : (i == 5) ? 8'h54 : 8'h20 + 8'($unsigned($random(seed)) % 48);
            v = $random(seed);
            run(8'h84, pn, v, ACK, 4'(i), 1'b1, (i % 2) ? 4'h3 : 4'h0);
            run(8'h05, pn, 32'h0, DAT);
            chk({o_reply_read_ok, o_reply_dp}, {1'b1, 4'(i)});
            chk(o_reply_data, v);
        end
        run(8'h84, 8'h20, 32'h1, ERR, 4'h6);
        run(8'h84, 8'h20, 32'h1, ERR, 4'h2, 1'b0);
        run(8'h84, 8'h20, 32'h1, ERR, 4'h0, 1'b1, 4'h1);
        run(8'h84, 8'h55, 32'h1, ERR);
        run(8'h05, 8'h55, 32'h0, ERR);
        run(8'h84, 8'h13, 32'h1, ACK);
        run(8'h05, 8'h54, 32'h0, DAT);
        chk(o_reply_read_ok, 0);
        settle();
        chk(n_nv, 3);
        // External input pin read
        @(posedge i_core_clk);
        i_discrete_inputs <= $random(seed);
        settle();
        run(8'h12, 8'h40, 32'h0, DAT);
        chk(o_reply_data, i_discrete_inputs);
        summarize();
    end
endmodule : servo_serial_command_handler_tb_top
`default_nettype wire
